/* hdl/dpram_host_defines.vh */
// timing constants for the dual-port memory port controller
// assumes one clock; the cycle counts other than SYNC_LAT are derived from ns figures and the clock period
// Behaviour
// - host selects memory or flag access exclusively, held for the whole write
// - slave collision flag asserted no later than start of competing write
// - host holds strobe low a minimum time after collision release
// - host changes address only while strobe, select or both bytes high
// - strobe write with outputs enabled needs a lengthened write pulse
// - host must not drive data while device outputs are still on
// - flag write then read keeps the memory path deselected throughout
`ifndef DPRAM_HOST_DEFINES_VH
`define DPRAM_HOST_DEFINES_VH

`define CLK_NS 4
`define T_WP_NS 40
`define T_WZ_NS 25
`define T_DW_NS 30
`define T_WH_NS 25
`define T_AA_NS 55
`define T_SWRD_NS 5
`define T_SOP_NS 15
`define NS2CYC(t) (((t) + `CLK_NS - 1) / `CLK_NS)
`define WZ_CYC `NS2CYC(`T_WZ_NS)
`define DW_CYC `NS2CYC(`T_DW_NS)
`define WP_REST_CYC `NS2CYC(`T_WP_NS - `T_WZ_NS)
`define WH_CYC `NS2CYC(`T_WH_NS)
`define AA_CYC `NS2CYC(`T_AA_NS)
`define RECOV_CYC `NS2CYC(`T_SWRD_NS + `T_SOP_NS)
`define SYNC_LAT 3
`define FLAG_ADDR_BITS 3

`endif

/* hdl/pin_sync.v */
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs on the clock's domain
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level_q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  always @(posedge clock) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* hdl/dpram_port_host.v */
// controller that drives one port of an asynchronous dual-port memory
// assumes the device is in slave role and collision_n is driven from the master side
`timescale 1ns/1ns
`include "dpram_host_defines.vh"
module dpram_port_host #(
  parameter AW = 15,
  parameter DW = 16
) (
  input wire clock,
  input wire rst,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire cmd_write,
  input wire cmd_flag,
  input wire [AW-1:0] cmd_addr,
  input wire [DW-1:0] cmd_wdata,
  input wire [1:0] cmd_be,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  output reg rsp_blocked,
  output reg [AW-1:0] addr_pin,
  output reg port_select_n,
  output reg flag_select_n,
  output reg write_strobe_n,
  output reg out_enable_n,
  output reg high_byte_select_n,
  output reg low_byte_select_n,
  output reg [DW-1:0] data_out,
  output reg data_oe,
  input wire [DW-1:0] data_in,
  input wire collision_n
);
  // ==========================================================
  // states
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_SETUP = 8'h02;
  localparam [7:0] S_STROBE = 8'h04;
  localparam [7:0] S_DRIVE = 8'h08;
  localparam [7:0] S_WAIT = 8'h10;
  localparam [7:0] S_HOLD = 8'h20;
  localparam [7:0] S_READ = 8'h40;
  localparam [7:0] S_RECOV = 8'h80;

  // ==========================================================
  // timing counts, cut to the counter width on purpose
  localparam integer WZ_I = `WZ_CYC;
  localparam integer DRV_I = (`DW_CYC > `WP_REST_CYC) ? `DW_CYC : `WP_REST_CYC;
  localparam integer WH_I = `WH_CYC;
  localparam integer RD_I = `AA_CYC + `SYNC_LAT;
  localparam integer RC_I = `RECOV_CYC;
  localparam [7:0] WZ = WZ_I[7:0];
  localparam [7:0] DRV = DRV_I[7:0];
  localparam [7:0] WH = WH_I[7:0];
  localparam [7:0] RD = RD_I[7:0];
  localparam [7:0] RC = RC_I[7:0];

  // byte lane select, kept high on flag access
  function sel_n;
    input is_flag;
    input lane_en;
    begin
      sel_n = is_flag | ~lane_en;
    end
  endfunction

  function [7:0] less1;
    input [7:0] v;
    begin
      less1 = (v > 8'h01) ? v - 8'h01 : 8'h00;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  wire coll_n_s;
  wire [DW-1:0] data_s;

  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_coll_sync (
    .clock(clock),
    .rst(rst),
    .pin(collision_n),
    .level_q(coll_n_s)
  );

  pin_sync #(.WIDTH(DW), .INIT({DW{1'b0}})) u_data_sync (
    .clock(clock),
    .rst(rst),
    .pin(data_in),
    .level_q(data_s)
  );

  // ==========================================================
  // sequencer
  reg [7:0] state_q;
  reg [7:0] cnt_q;
  reg write_q;
  reg flag_q;
  reg [1:0] be_q;

  always @(posedge clock) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 8'h00;
      write_q <= 1'b0;
      flag_q <= 1'b0;
      be_q <= 2'h0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      rsp_blocked <= 1'b0;
      addr_pin <= {AW{1'b0}};
      port_select_n <= 1'b1;
      flag_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      out_enable_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      data_out <= {DW{1'b0}};
      data_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            // address moves only while every select is high
            addr_pin <= cmd_addr;
            write_q <= cmd_write;
            flag_q <= cmd_flag;
            be_q <= cmd_be;
            // flag writes carry the value on bit zero only
            data_out <= cmd_flag ? {{(DW-1){1'b0}}, cmd_wdata[0]} : cmd_wdata;
            cmd_ready <= 1'b0;
            rsp_blocked <= 1'b0;
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          // exclusive memory or flag path
          port_select_n <= flag_q;
          flag_select_n <= ~flag_q;
          high_byte_select_n <= sel_n(flag_q, be_q[1]);
          low_byte_select_n <= sel_n(flag_q, be_q[0]);
          if (write_q) begin
            // strobe falls with the select so outputs stay off
            write_strobe_n <= 1'b0;
            out_enable_n <= 1'b1;
            cnt_q <= less1(WZ);
            state_q <= S_STROBE;
          end else begin
            out_enable_n <= 1'b0;
            cnt_q <= less1(RD);
            state_q <= S_READ;
          end
        end
        S_STROBE: begin
          // bus left free until device drivers are off
          if (cnt_q == 8'h00) begin
            data_oe <= 1'b1;
            cnt_q <= less1(DRV);
            state_q <= S_DRIVE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_DRIVE: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (!coll_n_s) begin
            // write held off while collision is low
            // flag seen on coll_n_s in the last counted pulse cycle is honoured; earlier lows are not sampled
            rsp_blocked <= 1'b1;
            state_q <= S_WAIT;
          end else begin
            write_strobe_n <= 1'b1;
            cnt_q <= less1(RC);
            state_q <= S_RECOV;
          end
        end
        S_WAIT: begin
          if (coll_n_s) begin
            cnt_q <= less1(WH);
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          // strobe kept low after collision release
          if (cnt_q == 8'h00) begin
            write_strobe_n <= 1'b1;
            cnt_q <= less1(RC);
            state_q <= S_RECOV;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_READ: begin
          // flag reads show the flag on every line
          if (cnt_q == 8'h00) begin
            rsp_rdata <= data_s;
            out_enable_n <= 1'b1;
            cnt_q <= less1(RC);
            state_q <= S_RECOV;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_RECOV: begin
          port_select_n <= 1'b1;
          flag_select_n <= 1'b1;
          high_byte_select_n <= 1'b1;
          low_byte_select_n <= 1'b1;
          data_oe <= 1'b0;
          if (cnt_q == 8'h00) begin
            rsp_valid <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* verif/dpram_port_host_checker.sv */
// pin-order checks for the memory port controller
// assumes binding onto dpram_port_host
`timescale 1ns/1ns
module dpram_port_host_checker #(parameter AW = 15) (
  input wire clock,
  input wire rst,
  input wire cmd_ready,
  input wire [AW-1:0] addr_pin,
  input wire port_select_n,
  input wire flag_select_n,
  input wire write_strobe_n,
  input wire out_enable_n,
  input wire high_byte_select_n,
  input wire low_byte_select_n,
  input wire data_oe,
  input wire collision_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // assertions
  sel_excl_a: assert property (port_select_n || flag_select_n)
    else $error("selects overlap");
  fall_together_a: assert property ($fell(write_strobe_n) |->
    $fell(port_select_n) || $fell(flag_select_n)) else $error("strobe fell alone");
  addr_hold_a: assert property ($changed(addr_pin) |->
    port_select_n && flag_select_n && $past(port_select_n) && $past(flag_select_n))
    else $error("address moved");
  drive_late_a: assert property ($rose(data_oe) |->
    !$past(write_strobe_n, 6) && out_enable_n) else $error("data driven early");
  flag_path_a: assert property (!flag_select_n |-> port_select_n
    && high_byte_select_n && low_byte_select_n) else $error("memory path on");
  busy_hold_a: assert property ($rose(write_strobe_n) |->
    collision_n && $past(collision_n, 7)) else $error("write ended in collision");
  pulse_len_a: assert property ($fell(write_strobe_n) |=>
    !write_strobe_n [*8]) else $error("write pulse short");
  idle_quiet_a: assert property (cmd_ready |-> port_select_n &&
    flag_select_n && write_strobe_n && !data_oe) else $error("pins busy in idle");
  cover property (!write_strobe_n && !collision_n);
  cover property ($rose(write_strobe_n) && !flag_select_n);
  cover property (!flag_select_n && !out_enable_n);
  cover property (!port_select_n && !write_strobe_n);
endmodule
bind dpram_port_host dpram_port_host_checker #(.AW(AW)) chk_inst (.clock, .rst,
  .cmd_ready, .addr_pin, .port_select_n, .flag_select_n, .write_strobe_n,
  .out_enable_n, .high_byte_select_n, .low_byte_select_n, .data_oe, .collision_n);

/* verif/dpram_dev_model.sv */
// behavioural model of one memory port with eight flags
// assumes collision_n is driven by the bench in the master's place
`timescale 1ns/1ns
module dpram_dev_model (
  input wire clock,
  input wire [14:0] addr_pin,
  input wire port_select_n,
  input wire flag_select_n,
  input wire write_strobe_n,
  input wire out_enable_n,
  input wire high_byte_select_n,
  input wire low_byte_select_n,
  input wire [15:0] data_out,
  input wire data_oe,
  input wire collision_n,
  output logic [15:0] data_in
);
  logic [15:0] mem [0:255];
  logic [7:0] flg = 8'hFF;
  logic [15:0] noise = 16'h0000;
  logic [15:0] d;
  // undriven bus shows an alternating inverse
  always @(posedge clock) noise <= ~noise;
  assign d = data_oe ? data_out : noise;
  // commit at end of write
  always @(posedge write_strobe_n) begin
    if (!port_select_n && collision_n) begin
      if (!low_byte_select_n) mem[addr_pin[7:0]][7:0] = d[7:0];
      if (!high_byte_select_n) mem[addr_pin[7:0]][15:8] = d[15:8];
    end
    if (!flag_select_n) flg[addr_pin[2:0]] = d[0];
  end
  always_comb begin
    data_in = noise;
    if (!out_enable_n && write_strobe_n && !port_select_n) begin
      data_in = mem[addr_pin[7:0]];
    end
    if (!out_enable_n && write_strobe_n && !flag_select_n) begin
      data_in = {16{flg[addr_pin[2:0]]}};
    end
  end
endmodule

/* verif/tb_dpram_port_host.sv */
// self-checking bench for the memory port controller
// assumes the device model and checker files are compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_dpram_port_host;
  logic clock = 0, rst = 1, cmd_valid = 0, cmd_write = 0, cmd_flag = 0, collision_n = 1;
  logic [14:0] cmd_addr = 0, addr_pin;
  logic [15:0] cmd_wdata = 0, rsp_rdata, data_out, data_in, ref_mem [0:255];
  logic [1:0] cmd_be = 0;
  logic cmd_ready, rsp_valid, rsp_blocked, port_select_n, flag_select_n, write_strobe_n;
  logic out_enable_n, high_byte_select_n, low_byte_select_n, data_oe;
  logic [7:0] ref_flg = 8'hFF;
  logic [17:0] expq [$];
  logic [17:0] e;
  integer n_mismatch = 0, checks = 0, seed = 32'h27fc, i, k;
  always #2 clock = ~clock;
  dpram_port_host dpram_port_host_inst (.clock, .rst, .cmd_valid, .cmd_ready, .cmd_write,
    .cmd_flag, .cmd_addr, .cmd_wdata, .cmd_be, .rsp_valid, .rsp_rdata, .rsp_blocked,
    .addr_pin, .port_select_n, .flag_select_n, .write_strobe_n, .out_enable_n,
    .high_byte_select_n, .low_byte_select_n, .data_out, .data_oe, .data_in, .collision_n);
  dpram_dev_model dpram_dev_model_inst (.clock, .addr_pin, .port_select_n, .flag_select_n,
    .write_strobe_n, .out_enable_n, .high_byte_select_n, .low_byte_select_n, .data_out,
    .data_oe, .collision_n, .data_in);
  task complete_run;
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========
  // command driver
  task op(input logic w, f, c, input logic [14:0] a, input logic [15:0] d,
          input logic [1:0] be);
    logic [15:0] x;
    x = f ? {16{ref_flg[a[2:0]]}} : ref_mem[a[7:0]];
    if (w && f) ref_flg[a[2:0]] = d[0];
    if (w && !f && be[0]) ref_mem[a[7:0]][7:0] = d[7:0];
    if (w && !f && be[1]) ref_mem[a[7:0]][15:8] = d[15:8];
    expq.push_back({!w, c, x});
    @(posedge clock);
    {cmd_valid, cmd_write, cmd_flag, cmd_addr, cmd_wdata, cmd_be} <= {1'b1, w, f, a, d, be};
    do @(negedge clock); while (!cmd_ready);
    @(posedge clock);
    cmd_valid <= 0;
    if (c) begin
      // bench as master: later port
      collision_n <= 0;
      repeat (30) @(posedge clock);
      // competing select released
      collision_n <= 1;
    end
    k = 0;
    do begin @(negedge clock); k++; end while (!rsp_valid && k < 200);
    if (!rsp_valid) n_mismatch++;
  endtask
  // ==========
  // response monitor
  always @(negedge clock) if (rsp_valid) begin
    e = expq.pop_front();
    `CHK("blocked", e[16], rsp_blocked)
    if (e[17]) `CHK("rdata", e[15:0], rsp_rdata)
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 0;
    for (i = 0; i < 8; i++) begin
      op(1, 0, 0, 15'(i * 33), 16'($random(seed)), 2'h3);
      op(0, 0, 0, 15'(i * 33), 16'h0000, 2'h3);
    end
    op(1, 0, 0, 15'h0021, 16'($random(seed)), 2'h1);
    op(1, 0, 0, 15'h0042, 16'($random(seed)), 2'h2);
    op(0, 0, 0, 15'h0021, 16'h0000, 2'h3);
    op(0, 0, 0, 15'h0042, 16'h0000, 2'h3);
    for (i = 0; i < 8; i++) begin
      op(1, 1, 0, 15'(i + 8), 16'($random(seed)) & 16'hFFFE, 2'h3);
      op(0, 1, 0, 15'(i), 16'h0000, 2'h3);
      op(1, 1, 0, 15'(i), 16'h0001, 2'h3);
      op(0, 1, 0, 15'(i), 16'h0000, 2'h3);
    end
    op(1, 0, 1, 15'h0009, 16'($random(seed)), 2'h3);
    op(0, 0, 0, 15'h0009, 16'h0000, 2'h3);
    complete_run;
  end
  // about four times the expected run
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule
